// >>> lsiu_top.v
// Load/store instruction unit: fetch, decode, one bus transfer, events.
// Bus master handshake: req held until a one-cycle ack; internal register
// file answers a read in the cycle after ireg_rd.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "lsiu_map.vh"
module lsiu_top #(
	parameter ADDR_W = 8,
	parameter [6:0] FBR_ADDR = 7'h08
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg bm_req_q,
	output reg bm_write_q,
	output reg bm_io_q,
	output reg [31:0] bm_addr_q,
	output reg [3:0] bm_be_q,
	output reg [31:0] bm_wdata_q,
	input wire bm_ack,
	input wire [31:0] bm_rdata,
	output reg [6:0] ireg_addr_q,
	output reg [3:0] ireg_be_q,
	output reg ireg_rd_q,
	output reg ireg_wr_q,
	output reg [31:0] ireg_wdata_q,
	input wire [31:0] ireg_rdata,
	output reg pf_flush_q,
	output reg irq_q
);
	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_F1 = 4'h1;
	localparam [3:0] S_F2S = 4'h2;
	localparam [3:0] S_F2 = 4'h3;
	localparam [3:0] S_DEC = 4'h4;
	localparam [3:0] S_RCAP = 4'h5;
	localparam [3:0] S_RWT = 4'h6;
	localparam [3:0] S_MEM = 4'h7;
	localparam [3:0] S_END = 4'h8;

	reg [3:0] state_q;
	reg run_q;
	reg [31:0] dsp_q;
	reg [31:0] dsa_q;
	reg [`LSIU_CTRL_W-1:0] ctrl_q;
	reg [`LSIU_EV_W-1:0] mask_q;
	reg [31:0] win_q;
	reg [31:0] cmd_q;
	reg [31:0] opw_q;
	reg [31:0] ea_q;
	reg [3:0] be_q;
	reg load_q;
	reg self_q;
	reg [6:0] sel_q;
	reg [`LSIU_EV_W-1:0] ev_q;
	reg aw_h_q;
	reg w_h_q;
	reg [ADDR_W-1:0] aw_a_q;
	reg [31:0] w_d_q;
	reg [3:0] w_s_q;

	wire [`LSIU_EV_W-1:0] sts;
	wire [`LSIU_EV_W-1:0] pend;
	wire ar_hs;
	wire do_wr;
	wire sts_clr;
	wire wr_ctrl;
	wire wr_dsp;
	wire [31:0] ea;
	wire [1:0] reg_align;
	wire [3:0] be;
	wire cnt_ok;
	wire is_ldst;
	wire is_load;
	wire io_sel;
	wire self_ref;
	wire fbr_load;
	reg [31:0] rd_mux;
	reg rd_hit;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	// Decode of the fetched pair
	assign is_ldst = (cmd_q[`LSIU_OP_HI:`LSIU_OP_LO] == `LSIU_OP_LDST);
	assign is_load = cmd_q[`LSIU_DIR_BIT];
	assign reg_align = cmd_q[`LSIU_REG_LO+1:`LSIU_REG_LO];
	// Relative form sign-extends the low 24 operand bits onto the base
	assign ea = cmd_q[`LSIU_REL_BIT] ?
		dsa_q + {{8{opw_q[`LSIU_OFS_HI]}}, opw_q[`LSIU_OFS_HI:0]} : opw_q;
	// Load reads its source, store writes its destination
	assign io_sel = is_load ? ctrl_q[`LSIU_CTRL_SOURCE_IO_SPACE_SELECT] : ctrl_q[`LSIU_CTRL_DESTINATION_IO_SPACE_SELECT];
	assign self_ref = (ea[31:`LSIU_WIN_LSB] == win_q[31:`LSIU_WIN_LSB]);
	assign fbr_load = is_load && (cmd_q[`LSIU_REG_HI:`LSIU_REG_LO] == FBR_ADDR);

	lsiu_byte_lane u_lane (
		.align(ea[1:0]),
		.cnt(cmd_q[`LSIU_CNT_HI:`LSIU_CNT_LO]),
		.be(be),
		.ok(cnt_ok)
	);

	genvar g;
	generate
		for (g = 0; g < `LSIU_EV_W; g = g + 1)
		begin : g_ev
			lsiu_evt_bit u_ev (
				.ref_clk(ref_clk),
				.sys_rst(sys_rst),
				.set(ev_q[g]),
				.clr(sts_clr),
				.mask(mask_q[g]),
				.sts(sts[g]),
				.pend(pend[g])
			);
		end
	endgenerate

	// Register bus: write and read channels
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign do_wr = aw_h_q && w_h_q && !s_axi_bvalid;
	assign sts_clr = ar_hs && (s_axi_araddr == `LSIU_OFF_STATUS);
	assign wr_ctrl = do_wr && (aw_a_q == `LSIU_OFF_CTRL);
	assign wr_dsp = do_wr && (aw_a_q == `LSIU_OFF_DSP) && !run_q;

	always @*
	begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`LSIU_OFF_CTRL: rd_mux = {28'h0, ctrl_q[`LSIU_CTRL_W-1:1], run_q};
			`LSIU_OFF_DSP: rd_mux = dsp_q;
			`LSIU_OFF_DSA: rd_mux = dsa_q;
			`LSIU_OFF_STATUS: rd_mux = {29'h0, sts};
			`LSIU_OFF_MASK: rd_mux = {29'h0, mask_q};
			`LSIU_OFF_WIN: rd_mux = win_q;
			`LSIU_OFF_INFO: rd_mux = {17'h0, sel_q, 4'h0, state_q};
			default:
			begin
				rd_mux = 32'h0;
				rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LSIU_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `LSIU_RESP_OKAY;
			aw_h_q <= 1'b0;
			w_h_q <= 1'b0;
			aw_a_q <= {ADDR_W{1'b0}};
			w_d_q <= 32'h0;
			w_s_q <= 4'h0;
			ctrl_q <= {`LSIU_CTRL_W{1'b0}};
			dsa_q <= 32'h0;
			mask_q <= {`LSIU_EV_W{1'b0}};
			win_q <= 32'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_h_q <= 1'b1;
				aw_a_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_h_q <= 1'b1;
				w_d_q <= s_axi_wdata;
				w_s_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_wr)
			begin
				aw_h_q <= 1'b0;
				w_h_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `LSIU_RESP_OKAY;
				case (aw_a_q)
					`LSIU_OFF_CTRL:
						if (w_s_q[0])
							ctrl_q <= w_d_q[`LSIU_CTRL_W-1:0];
					`LSIU_OFF_DSP: ;
					`LSIU_OFF_DSA: dsa_q <= merge(dsa_q, w_d_q, w_s_q);
					`LSIU_OFF_STATUS: ;
					`LSIU_OFF_MASK:
						if (w_s_q[0])
							mask_q <= w_d_q[`LSIU_EV_W-1:0];
					`LSIU_OFF_WIN: win_q <= merge(win_q, w_d_q, w_s_q);
					`LSIU_OFF_INFO: ;
					default: s_axi_bresp <= `LSIU_RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (ar_hs)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? `LSIU_RESP_OKAY : `LSIU_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Instruction engine
	always @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= S_IDLE;
			run_q <= 1'b0;
			dsp_q <= 32'h0;
			cmd_q <= 32'h0;
			opw_q <= 32'h0;
			ea_q <= 32'h0;
			be_q <= 4'h0;
			load_q <= 1'b0;
			self_q <= 1'b0;
			sel_q <= 7'h0;
			ev_q <= {`LSIU_EV_W{1'b0}};
			bm_req_q <= 1'b0;
			bm_write_q <= 1'b0;
			bm_io_q <= 1'b0;
			bm_addr_q <= 32'h0;
			bm_be_q <= 4'h0;
			bm_wdata_q <= 32'h0;
			ireg_addr_q <= 7'h0;
			ireg_be_q <= 4'h0;
			ireg_rd_q <= 1'b0;
			ireg_wr_q <= 1'b0;
			ireg_wdata_q <= 32'h0;
			pf_flush_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			ev_q <= {`LSIU_EV_W{1'b0}};
			pf_flush_q <= 1'b0;
			irq_q <= |pend;
			// A stop takes effect between instructions only
			if (wr_ctrl && w_s_q[0])
				run_q <= w_d_q[`LSIU_CTRL_RUN];
			if (wr_dsp)
				dsp_q <= merge(dsp_q, w_d_q, w_s_q);
			case (state_q)
				S_IDLE:
					if (run_q)
					begin
						bm_req_q <= 1'b1;
						bm_write_q <= 1'b0;
						bm_io_q <= 1'b0;
						bm_addr_q <= dsp_q;
						bm_be_q <= 4'hf;
						state_q <= S_F1;
					end
				S_F1:
					if (bm_ack)
					begin
						bm_req_q <= 1'b0;
						cmd_q <= bm_rdata;
						dsp_q <= dsp_q + `LSIU_WORD_BYTES;
						state_q <= S_F2S;
					end
				S_F2S:
				begin
					bm_req_q <= 1'b1;
					bm_addr_q <= dsp_q;
					state_q <= S_F2;
				end
				S_F2:
					if (bm_ack)
					begin
						bm_req_q <= 1'b0;
						opw_q <= bm_rdata;
						dsp_q <= dsp_q + `LSIU_WORD_BYTES;
						state_q <= S_DEC;
					end
				S_DEC:
				begin
					ea_q <= ea;
					be_q <= be;
					load_q <= is_load;
					self_q <= self_ref;
					ireg_addr_q <= cmd_q[`LSIU_REG_HI:`LSIU_REG_LO];
					if (!is_ldst)
					begin
						// Other instruction classes belong to other units
						ev_q[`LSIU_EV_FOREIGN] <= 1'b1;
						run_q <= 1'b0;
						state_q <= S_IDLE;
					end
					else if (!cnt_ok || (reg_align != ea[1:0]) || fbr_load)
					begin
						ev_q[`LSIU_EV_ILL] <= 1'b1;
						run_q <= 1'b0;
						state_q <= S_IDLE;
					end
					else if (is_load)
					begin
						bm_req_q <= 1'b1;
						bm_write_q <= 1'b0;
						bm_io_q <= io_sel;
						bm_addr_q <= ea;
						bm_be_q <= be;
						state_q <= S_MEM;
					end
					else
					begin
						ireg_rd_q <= 1'b1;
						if (ctrl_q[`LSIU_CTRL_PFEN] && !cmd_q[`LSIU_NF_BIT])
							pf_flush_q <= 1'b1;
						state_q <= S_RCAP;
					end
				end
				S_RCAP:
				begin
					ireg_rd_q <= 1'b0;
					state_q <= S_RWT;
				end
				S_RWT:
				begin
					bm_wdata_q <= ireg_rdata;
					bm_req_q <= 1'b1;
					bm_write_q <= 1'b1;
					bm_io_q <= io_sel;
					bm_addr_q <= ea_q;
					bm_be_q <= be_q;
					state_q <= S_MEM;
				end
				S_MEM:
					if (bm_ack)
					begin
						bm_req_q <= 1'b0;
						bm_write_q <= 1'b0;
						// Data from a self-referencing read is junk; keep the register
						if (load_q && !self_q)
						begin
							ireg_wr_q <= 1'b1;
							ireg_be_q <= be_q;
							ireg_wdata_q <= bm_rdata;
						end
						state_q <= S_END;
					end
				S_END:
				begin
					ireg_wr_q <= 1'b0;
					if (self_q)
					begin
						sel_q <= ea_q[`LSIU_WIN_LSB-1:0];
						ev_q[`LSIU_EV_ILL] <= 1'b1;
						run_q <= 1'b0;
					end
					else
						ev_q[`LSIU_EV_DONE] <= 1'b1;
					state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule // lsiu_top

// >>> lsiu_map.vh
// Constants of the load/store instruction unit: offsets, fields, codes.
// Included by the top, byte lane and test files; holds definitions only.
// What this block does
// - Fetch each instruction as two words: command word, then operand word.
// - Move at most four bytes per instruction.
// - Byte count limited by address bits 1:0 so no word boundary is crossed.
// - Register and external address share the same byte alignment.
// - Address in own register window: run the cycle, then raise illegal interrupt.
// - Space select bits pick memory or I/O commands for the external address.
// - Command word bits 31:29 equal to 111 mark a load/store.
// - Relative bit clear: absolute address; set: base plus signed 24-bit offset.
// - Store with prefetch enabled flushes prefetch unless no-flush bit is set.
// - Direction bit 1 means load, 0 means store.
// - Bits 22:16 select the internal register.
// - First-byte-received register cannot be loaded but may be stored.
// - Byte count comes from bits 2:0 of the command word.
// - All 32 operand bits are the address; the low 24 bits are the base offset.
// - Self-referencing address selects the register named by its low seven bits.
`ifndef LSIU_MAP_VH
`define LSIU_MAP_VH
`define LSIU_OFF_CTRL 8'h00
`define LSIU_OFF_DSP 8'h04
`define LSIU_OFF_DSA 8'h08
`define LSIU_OFF_STATUS 8'h0c
`define LSIU_OFF_MASK 8'h10
`define LSIU_OFF_WIN 8'h14
`define LSIU_OFF_INFO 8'h18
`define LSIU_CTRL_RUN 0
`define LSIU_CTRL_PFEN 1
`define LSIU_CTRL_SOURCE_IO_SPACE_SELECT 2
`define LSIU_CTRL_DESTINATION_IO_SPACE_SELECT 3
`define LSIU_CTRL_W 4
`define LSIU_OP_HI 31
`define LSIU_OP_LO 29
`define LSIU_OP_LDST 3'h7
`define LSIU_REL_BIT 28
`define LSIU_NF_BIT 25
`define LSIU_DIR_BIT 24
`define LSIU_REG_HI 22
`define LSIU_REG_LO 16
`define LSIU_CNT_HI 2
`define LSIU_CNT_LO 0
`define LSIU_OFS_HI 23
`define LSIU_WIN_LSB 7
`define LSIU_EV_DONE 0
`define LSIU_EV_ILL 1
`define LSIU_EV_FOREIGN 2
`define LSIU_EV_W 3
`define LSIU_WORD_BYTES 32'h00000004
`define LSIU_MAX_BYTES 4'h4
`define LSIU_RESP_OKAY 2'h0
`define LSIU_RESP_SLVERR 2'h2
`endif

// >>> lsiu_byte_lane.v
// Byte lane and count check for one load/store transfer.
// Pure combinational; the caller registers the results.
`timescale 1ns/1ps
`include "lsiu_map.vh"
module lsiu_byte_lane (
	input wire [1:0] align,
	input wire [2:0] cnt,
	output wire [3:0] be,
	output wire ok
);
	wire [3:0] sum;
	reg [3:0] m;
	assign sum = {2'b00, align} + {1'b0, cnt};
	// Zero bytes or a lane run past byte 3 is refused
	assign ok = (cnt != 3'h0) && (sum <= `LSIU_MAX_BYTES);
	always @*
	begin
		case (cnt)
			3'h1: m = 4'h1;
			3'h2: m = 4'h3;
			3'h3: m = 4'h7;
			3'h4: m = 4'hf;
			default: m = 4'h0;
		endcase
	end
	assign be = m << align;
endmodule // lsiu_byte_lane

// >>> lsiu_evt_bit.v
// One sticky event bit with its mask.
// Set and clear are one-cycle pulses in the ref_clk domain.
`timescale 1ns/1ps
module lsiu_evt_bit (
	input wire ref_clk,
	input wire sys_rst,
	input wire set,
	input wire clr,
	input wire mask,
	output wire sts,
	output wire pend
);
	reg sts_q;
	// Set wins over a clear in the same cycle so no event is lost
	always @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			sts_q <= 1'b0;
		else if (set)
			sts_q <= 1'b1;
		else if (clr)
			sts_q <= 1'b0;
	end
	assign sts = sts_q;
	assign pend = sts_q & mask;
endmodule // lsiu_evt_bit

// >>> lsiu_top_props.sv
// Checker for lsiu_top: bus master, register port and flush outputs.
// Assumes one clock domain; bound into every lsiu_top instance.
`timescale 1ns/1ps
module lsiu_top_props #(
	parameter [6:0] FBR_ADDR = 7'h08
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire bm_req_q,
	input wire bm_write_q,
	input wire [31:0] bm_addr_q,
	input wire [3:0] bm_be_q,
	input wire bm_ack,
	input wire [6:0] ireg_addr_q,
	input wire [3:0] ireg_be_q,
	input wire ireg_rd_q,
	input wire ireg_wr_q,
	input wire pf_flush_q
);
default clocking cb @(posedge ref_clk); endclocking
default disable iff (sys_rst);
a_req_hold: assert property (
	bm_req_q && !bm_ack |=> bm_req_q && $stable(bm_addr_q) && $stable(bm_be_q))
	else $error("bus request changed before ack");
a_req_drop: assert property (
	bm_req_q && bm_ack |=> !bm_req_q) else $error("bus request held after ack");
a_lane_align: assert property (
	bm_req_q |-> bm_be_q != 4'h0 && (bm_be_q & ((4'h1 << bm_addr_q[1:0]) - 4'h1)) == 4'h0)
	else $error("byte enables below address alignment");
a_load_write: assert property (
	ireg_wr_q |-> $past(bm_ack) && !$past(bm_write_q))
	else $error("register write without a completed bus read");
a_fbr_locked: assert property (
	ireg_wr_q |-> ireg_addr_q != FBR_ADDR) else $error("first byte register loaded");
a_reg_align: assert property (
	ireg_wr_q |-> (ireg_be_q & ((4'h1 << ireg_addr_q[1:0]) - 4'h1)) == 4'h0)
	else $error("register lanes below register alignment");
a_store_follow: assert property (
	ireg_rd_q |-> ##[1:4] (bm_req_q && bm_write_q)) else $error("store write missing");
a_flush_store: assert property (
	pf_flush_q |-> ##[0:4] (bm_req_q && bm_write_q)) else $error("flush outside a store");
endmodule // lsiu_top_props
bind lsiu_top lsiu_top_props #(.FBR_ADDR(FBR_ADDR)) u_props (.*);

// >>> lsiu_mem_model.sv
// Host bus target model: 64-word memory and a register file reader.
// Addresses alias on bits 7:2; ack comes after delay stall cycles.
`timescale 1ns/1ps
module lsiu_mem_model (
	input wire ref_clk,
	input wire sys_rst,
	input wire bm_req_q,
	input wire bm_write_q,
	input wire [31:0] bm_addr_q,
	input wire [3:0] bm_be_q,
	input wire [31:0] bm_wdata_q,
	input wire [3:0] delay,
	input wire ireg_rd_q,
	input wire [6:0] ireg_addr_q,
	output reg bm_ack,
	output reg [31:0] bm_rdata,
	output reg [31:0] ireg_rdata
);
reg [31:0] mem [0:63];
reg [3:0] wait_q;
integer b;
always @(posedge ref_clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		bm_ack <= 1'b0;
		wait_q <= 4'h0;
		bm_rdata <= 32'h5a5a5a5a;
		ireg_rdata <= 32'h0f0f0f0f;
	end
	else
	begin
		bm_ack <= 1'b0;
		// Idle buses toggle so stale data never looks valid
		bm_rdata <= ~bm_rdata;
		ireg_rdata <= ireg_rd_q ? {4{1'b1, ireg_addr_q}} : ~ireg_rdata;
		if (bm_req_q && !bm_ack && wait_q != delay)
			wait_q <= wait_q + 4'h1;
		else if (bm_req_q && !bm_ack)
		begin
			bm_ack <= 1'b1;
			wait_q <= 4'h0;
			bm_rdata <= mem[bm_addr_q[7:2]];
			if (bm_write_q)
				for (b = 0; b < 4; b = b + 1)
					if (bm_be_q[b])
						mem[bm_addr_q[7:2]][8*b +: 8] <= bm_wdata_q[8*b +: 8];
		end
	end
end
endmodule // lsiu_mem_model

// >>> test_load_store_instruction_unit.sv
// Self-checking bench for lsiu_top running small programs.
// Assumes lsiu_mem_model answers bus and register reads.
`timescale 1ns/1ps
`include "lsiu_map.vh"
module test_load_store_instruction_unit;
reg ref_clk = 1'b0;
reg sys_rst = 1'b1;
reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
reg [31:0] s_axi_wdata = 32'h0;
reg [3:0] s_axi_wstrb = 4'hf, delay = 4'h0;
reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata, bm_addr_q, bm_wdata_q, bm_rdata, ireg_wdata_q, ireg_rdata;
wire bm_req_q, bm_write_q, bm_io_q, bm_ack, ireg_rd_q, ireg_wr_q, pf_flush_q, irq_q;
wire [3:0] bm_be_q, ireg_be_q;
wire [6:0] ireg_addr_q;
integer fails = 0, total_checks = 0, wr_n, fl_n, i, k;
reg [37:0] log[$];
reg [42:0] wr_d;
reg [31:0] d, sts;
reg [1:0] rsp;
reg irq_v;
// Each entry: operand byte, register index, byte count; every one must be refused
localparam [119:0] BAD = {24'h221203, 24'h221101, 24'h221200, 24'h201005, 24'h200801};
lsiu_top dut_u (.*);
lsiu_mem_model p_u (.*);
initial forever #2 ref_clk = ~ref_clk;
always @(posedge ref_clk)
begin
	if (bm_req_q && bm_ack)
		log.push_back({bm_write_q, bm_io_q, bm_be_q, bm_addr_q});
	if (ireg_wr_q)
	begin
		wr_n = wr_n + 1;
		wr_d = {ireg_addr_q, ireg_be_q, ireg_wdata_q};
	end
	if (pf_flush_q)
		fl_n = fl_n + 1;
end
task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
	total_checks = total_checks + 1;
	if (seen !== exp)
	begin
		fails = fails + 1;
		$display("Error %s expected %h seen %h", what, exp, seen);
	end
endtask
task finish_test;
	if (fails == 0 && total_checks > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
endtask
task axw(input [7:0] a, input [31:0] v);
	@(posedge ref_clk);
	s_axi_awaddr <= a;
	s_axi_wdata <= v;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	do
	begin
		@(posedge ref_clk);
		if (s_axi_awready)
			s_axi_awvalid <= 1'b0;
		if (s_axi_wready)
			s_axi_wvalid <= 1'b0;
	end
	while (!s_axi_bvalid);
	rsp = s_axi_bresp;
	s_axi_bready <= 1'b0;
endtask
task axr(input [7:0] a);
	@(posedge ref_clk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	do
	begin
		@(posedge ref_clk);
		if (s_axi_arready)
			s_axi_arvalid <= 1'b0;
	end
	while (!s_axi_rvalid);
	d = s_axi_rdata;
	rsp = s_axi_rresp;
	s_axi_rready <= 1'b0;
endtask
// Starts at pc, waits for halt, reads and so clears the status
task run(input [31:0] pc, input [31:0] ctrl);
	log.delete();
	wr_n = 0;
	fl_n = 0;
	axw(`LSIU_OFF_DSP, pc);
	axw(`LSIU_OFF_CTRL, ctrl);
	d = 32'h1;
	for (i = 0; i < 60 && d[0]; i = i + 1)
		axr(`LSIU_OFF_CTRL);
	// A program that never halts counts as a mismatch
	check("halt", d[0], 1'b0);
	irq_v = irq_q;
	axr(`LSIU_OFF_STATUS);
	sts = d;
endtask
task t_axi;
	axr(8'h1c);
	check("unmapped read", {rsp, d}, {2'h2, 32'h0});
	axw(8'h1c, 32'h1);
	check("unmapped write", rsp, 2'h2);
endtask
task t_load;
	delay <= 4'h3;
	p_u.mem[8] = 32'h11223344;
	p_u.mem[16] = 32'he1100004;
	p_u.mem[17] = 32'h00000020;
	p_u.mem[18] = 32'h0;
	axw(`LSIU_OFF_MASK, 32'h7);
	// Source in I/O space: the load must take the source select, not the destination one
	run(32'h40, 32'h5);
	check("fetch two", log[1], {2'b00, 4'hf, 32'h44});
	check("load cycle", log[2], {2'b01, 4'hf, 32'h20});
	check("load reg", wr_d, {7'h10, 4'hf, 32'h11223344});
	check("irq", irq_v, 1'b1);
	check("status", sts, 32'h5);
	axr(`LSIU_OFF_STATUS);
	repeat (2) @(posedge ref_clk);
	check("status clear", {irq_q, d}, {1'b0, 32'h0});
	axw(`LSIU_OFF_MASK, 32'h0);
endtask
task t_store;
	axw(`LSIU_OFF_DSA, 32'h30);
	for (k = 0; k < 3; k = k + 1)
	begin
		delay <= k[3:0];
		p_u.mem[11] = 32'h0;
		p_u.mem[24] = k == 1 ? 32'hf2120002 : 32'hf0120002;
		p_u.mem[25] = 32'h00fffffe;
		p_u.mem[26] = 32'h0;
		run(32'h60, k == 2 ? 32'h9 : 32'hb);
		check("store cycle", log[2], {2'b11, 4'hc, 32'h2e});
		check("store data", p_u.mem[11], 32'h92920000);
		check("flush", fl_n, k == 0);
		check("masked irq", irq_v, 1'b0);
	end
endtask
task t_illegal;
	for (k = 0; k < 5; k = k + 1)
	begin
		p_u.mem[16] = 32'he1000000 | {BAD[k*24+8 +: 8], 16'h0} | BAD[k*24 +: 8];
		p_u.mem[17] = BAD[k*24+16 +: 8];
		run(32'h40, 32'h1);
		check("bad cycles", log.size(), 2);
		check("bad status", sts, 32'h2);
		check("bad write", wr_n, 0);
	end
endtask
task t_self;
	axw(`LSIU_OFF_WIN, 32'h80);
	p_u.mem[16] = 32'he1050001;
	p_u.mem[17] = 32'h85;
	// Destination select set, source clear: a load must still use memory space
	run(32'h40, 32'h9);
	check("self cycle", log[2], {2'b00, 4'h2, 32'h85});
	check("self status", {wr_n[7:0], sts}, {8'h0, 32'h2});
	axr(`LSIU_OFF_INFO);
	check("self index", d[14:8], 7'h05);
endtask
initial
begin
	repeat (2) @(posedge ref_clk);
	sys_rst <= 1'b0;
	axw(`LSIU_OFF_WIN, 32'h80000000);
	t_axi;
	t_load;
	t_store;
	t_illegal;
	t_self;
	finish_test;
end
initial
begin
	#100000;
	fails = fails + 1;
	finish_test;
end
endmodule // test_load_store_instruction_unit
